// File: src/sfi_pkg.sv
// Slave FIFO interface: shared constants and carrier types
package sfi_pkg;
	localparam int NF = 4;
	localparam int PW = 11;
	localparam int BW = 13;
	localparam int DW = 16;
	localparam logic [10:0] PKT_512 = 11'h200;
	localparam logic [10:0] PKT_1024 = 11'h400;
	localparam logic [1:0] BUF_2X = 2'h0;
	localparam logic [1:0] BUF_3X = 2'h1;
	localparam logic [1:0] BUF_4X = 2'h2;
	localparam int POL_FULL = 0;
	localparam int POL_EMPTY = 1;
	localparam int POL_WR = 2;
	localparam int POL_RD = 3;
	localparam int POL_OE = 4;
	localparam int POL_PEND = 5;
	localparam logic [5:0] POL_RESET = 6'h00;
	localparam int ALT_CS = 6;
	localparam logic [12:0] PFC_OUT_RESET = 13'h0200;
	localparam logic [12:0] PFC_IN_RESET = 13'h0000;
	localparam logic [2:0] PKTS_IN_RESET = 3'h1;

	typedef enum logic [1:0] {sfi_bulk, sfi_intr, sfi_iso} sfi_xfer_type;

	// Per-endpoint configuration
	typedef struct packed {
		logic         dir_in;
		sfi_xfer_type xfer;
		logic         size_1024;
		logic [1:0]   bufs;
		logic         auto_in_commit;
		logic         zero_len;
		logic         packet_status_mode;
		logic         level_compare_direction;
		logic [2:0]   committed_packet_threshold;
		logic [12:0]  level_threshold_count;
		logic [10:0]  auto_in_packet_length;
	} sfi_ep_type;

	localparam sfi_ep_type EP_OUT_RESET = '{1'b0, sfi_bulk, 1'b0, BUF_2X,
		1'b0, 1'b0, 1'b0, 1'b1, 3'h0, PFC_OUT_RESET, PKT_512};
	localparam sfi_ep_type EP_IN_RESET = '{1'b1, sfi_bulk, 1'b0, BUF_2X,
		1'b0, 1'b0, 1'b0, 1'b0, PKTS_IN_RESET, PFC_IN_RESET, PKT_512};

	// Whole configuration bundle, held in the core clock domain
	typedef struct packed {
		sfi_ep_type [NF-1:0] ep;
		logic [5:0]          pin_polarity_config;
		logic                cs_en;
		logic                amode;
	} sfi_cfg_type;

	localparam sfi_cfg_type CFG_RESET = '{'{EP_IN_RESET, EP_IN_RESET,
		EP_OUT_RESET, EP_OUT_RESET}, POL_RESET, 1'b0, 1'b0};

	// Processor buffer window request
	typedef struct packed {
		logic [1:0]    fifo;
		logic          wr;
		logic [PW-1:0] off;
		logic [DW-1:0] data;
	} sfi_win_type;

	// Slave port pins as sampled
	typedef struct packed {
		logic          cs;
		logic          pend;
		logic          oe;
		logic          rd;
		logic          wr;
		logic [1:0]    sel;
		logic [DW-1:0] data;
	} sfi_pins_type;
endpackage

// File: src/sfi_slave_fifo.sv
// Slave FIFO block: four endpoint FIFOs behind an external master port
//
// Contract
// (RULE1) Packet-end commits the current IN packet whatever its length.
// (RULE2) Auto-in commit fires when the packet reaches the auto-in length.
// (RULE3) Master pads a short trailing packet or ends it with packet-end.
// (RULE4) Packet-end on an empty packet commits zero length if allowed.
// (RULE5) Packet-end is active low after reset; polarity is configurable.
// (RULE6) Master asserts packet-end only while a buffer is free.
// (RULE7) Chip select is port A bit seven, enabled by alt-config bit 6.
// (RULE8) Deselected: data bus floats, all strobes are ignored.
// (RULE9) Sync write: select, wait not full, data, one-clock write strobe.
// (RULE10) Sync read: select, output enable, wait not empty, one-clock read.
// (RULE11) Async write: select, wait not full, data, pulse write strobe.
// (RULE12) Async read: select, wait not empty, strobes, sample, release.
// (RULE13) Each FIFO is a processor-side readable and writable window.
// (RULE14) Firmware sets dynamic-out and enhanced-packet enables.
// (RULE15) Endpoints two/six size 512 or 1024; four/eight fixed 512.
// (RULE16) Endpoints two/six 2x, 3x or 4x; four/eight fixed 2x.
// (RULE17) Each endpoint has a transfer type and a direction.
// (RULE18) Reset: two/four bulk OUT, six/eight bulk IN, 512, 2x.
// (RULE19) OUT level flag compares FIFO bytes to a 13-bit threshold.
// (RULE20) IN, status mode 1: compare current packet bytes to 10 bits.
// (RULE21) IN, status mode 0: compare packets and bytes together.
// (RULE22) Flag A default: level of selected FIFO, half full/empty.
// (RULE23) Sync mode captures data each rising edge with write active.
// (RULE24) Select 00/01/10/11 picks endpoints two/four/six/eight.
// (RULE25) Indexed flags: A level, B full, C empty of selected FIFO.
// (RULE26) Async mode advances read pointer on read strobe release.
// (RULE27) Byte and packet counts live in the interface clock domain.
`timescale 1ns/10ps
module sfi_slave_fifo (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire logic                     interface_clock,
	input  wire logic                     cfg_load,
	input  wire sfi_pkg::sfi_ep_type [3:0] cfg_ep,
	input  wire logic [5:0]               pin_polarity_config,
	input  wire logic [7:0]               port_a_alt_config,
	input  wire logic                     async_mode,
	input  wire logic                     win_req,
	input  wire sfi_pkg::sfi_win_type     win_cmd,
	output logic                          win_done,
	output logic [15:0]                   win_rdata,
	input  wire logic [3:0]               usb_release,
	input  wire logic [1:0]               fifo_select,
	input  wire logic                     fifo_chip_select,
	input  wire logic                     fifo_write_strobe,
	input  wire logic                     fifo_read_strobe,
	input  wire logic                     fifo_output_enable,
	input  wire logic                     packet_end_strobe,
	input  wire logic [15:0]              fifo_data_bus_in,
	output logic [15:0]                   fifo_data_bus_out,
	output logic                          fifo_data_bus_oe_n,
	output logic                          flag_pin_a,
	output logic                          flag_pin_b,
	output logic                          flag_pin_c
);
	localparam int PW = sfi_pkg::PW;
	localparam int BW = sfi_pkg::BW;
	localparam int DW = sfi_pkg::DW;

	// Core clock domain state
	typedef struct packed {
		sfi_pkg::sfi_cfg_type cfg;
		sfi_pkg::sfi_win_type cmd;
		logic                 req;
		logic                 busy;
		logic                 ack1;
		logic                 ack2;
		logic                 ack_seen;
		logic                 done;
		logic [DW-1:0]        rdata;
		logic [3:0]           rel;
	} sfi_core_type;

	// Interface clock domain state
	typedef struct packed {
		sfi_pkg::sfi_cfg_type     c1;
		sfi_pkg::sfi_cfg_type     c2;
		sfi_pkg::sfi_pins_type    p1;
		sfi_pkg::sfi_pins_type    p2;
		sfi_pkg::sfi_pins_type    pv;
		logic                     req1;
		logic                     req2;
		logic                     req_seen;
		logic                     ack;
		logic [DW-1:0]            rdata;
		logic [3:0]               rel1;
		logic [3:0]               rel2;
		logic [3:0]               rel_seen;
		logic [3:0][BW-1:0]       bytes;
		logic [3:0][10:0]         cur;
		logic [3:0][2:0]          cnt;
		logic [3:0][1:0]          head;
		logic [3:0][3:0][10:0]    lens;
		logic [3:0][PW-1:0]       wp;
		logic [3:0][PW-1:0]       rp;
		logic                     fa;
		logic                     fb;
		logic                     fc;
		logic                     oe_n;
		logic [DW-1:0]            dout;
	} sfi_link_type;

	localparam sfi_core_type CORE_RESET = '{cfg: sfi_pkg::CFG_RESET,
		default: '0};
	localparam sfi_link_type LINK_RESET = '{c1: sfi_pkg::CFG_RESET,
		c2: sfi_pkg::CFG_RESET, p1: '1, p2: '1, pv: '1, fb: 1'b1,
		fc: 1'b0, oe_n: 1'b1, default: '0};

	sfi_core_type          q;
	sfi_core_type          next_q;
	sfi_link_type          s;
	sfi_link_type          next_s;
	logic [DW-1:0]         lmem [4][1<<PW];
	logic                  lmem_we;
	logic [1:0]            lmem_f;
	logic [PW-1:0]         lmem_a;
	logic [DW-1:0]         lmem_d;
	sfi_pkg::sfi_cfg_type  c;
	sfi_pkg::sfi_pins_type p;
	sfi_pkg::sfi_pins_type pins_raw;
	sfi_pkg::sfi_win_type  wc;
	logic                  cs_ok;
	logic                  wa;
	logic                  wv;
	logic                  ra;
	logic                  rv;
	logic                  pa;
	logic                  pva;
	logic                  wr_ev;
	logic                  rd_ev;
	logic                  pe_ev;
	logic                  wr_ok;
	logic                  rd_ok;
	logic                  pe_ok;
	logic                  au_ok;
	logic                  push;
	logic [1:0]            f;
	logic [1:0]            pf;
	logic [DW-1:0]         pd;
	logic [10:0]           len;
	logic [10:0]           nc;
	logic [3:0][10:0]      sz;
	logic [3:0][2:0]       nb;
	logic [3:0][12:0]      cap;
	logic [3:0]            full;
	logic [3:0]            empty;
	logic [3:0]            lvl;

	assign pins_raw = '{fifo_chip_select, packet_end_strobe,
		fifo_output_enable, fifo_read_strobe, fifo_write_strobe,
		fifo_select, fifo_data_bus_in};

	// Core side: configuration, window handshake, release toggles
	always_comb begin
		next_q = q;
		next_q.done = 1'b0;
		if (cfg_load) begin
			next_q.cfg.ep = cfg_ep; // [RULE17]
			for (int i = 1; i < sfi_pkg::NF; i += 2) begin
				next_q.cfg.ep[i].size_1024 = 1'b0; // [RULE15]
				next_q.cfg.ep[i].bufs = sfi_pkg::BUF_2X; // [RULE16]
			end
			next_q.cfg.pin_polarity_config = pin_polarity_config; // [RULE5]
			next_q.cfg.cs_en = port_a_alt_config[sfi_pkg::ALT_CS]; // [RULE7]
			next_q.cfg.amode = async_mode;
		end
		if (win_req && !q.busy) begin
			next_q.cmd = win_cmd;
			next_q.req = !q.req;
			next_q.busy = 1'b1;
		end
		next_q.ack1 = s.ack;
		next_q.ack2 = q.ack1;
		if (q.ack2 != q.ack_seen) begin
			next_q.ack_seen = q.ack2;
			next_q.busy = 1'b0;
			next_q.done = 1'b1;
			next_q.rdata = s.rdata; // [RULE13]
		end
		next_q.rel = q.rel ^ usb_release;
	end

	// Core register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q <= CORE_RESET; // [RULE18]
		end else begin
			q <= next_q;
		end
	end

	// Link side: pin decode, counters, flags, data path
	always_comb begin
		next_s = s;
		lmem_we = 1'b0;
		lmem_f = 2'h0;
		lmem_a = '0;
		lmem_d = '0;
		wc = q.cmd;
		next_s.c1 = q.cfg;
		next_s.c2 = s.c1;
		next_s.p1 = pins_raw;
		next_s.p2 = s.p1;
		next_s.req1 = q.req;
		next_s.req2 = s.req1;
		next_s.rel1 = q.rel;
		next_s.rel2 = s.rel1;
		c = s.c2;
		p = c.amode ? s.p2 : pins_raw;
		next_s.pv = p;
		f = p.sel; // [RULE24]
		cs_ok = !c.cs_en || !p.cs; // [RULE8]
		wa = p.wr == c.pin_polarity_config[sfi_pkg::POL_WR];
		wv = s.pv.wr == c.pin_polarity_config[sfi_pkg::POL_WR];
		ra = p.rd == c.pin_polarity_config[sfi_pkg::POL_RD];
		rv = s.pv.rd == c.pin_polarity_config[sfi_pkg::POL_RD];
		pa = p.pend == c.pin_polarity_config[sfi_pkg::POL_PEND]; // [RULE5]
		pva = s.pv.pend == c.pin_polarity_config[sfi_pkg::POL_PEND];
		// Sync: level of strobe; async: release edge [RULE11] [RULE26]
		wr_ev = cs_ok && (c.amode ? (wv && !wa) : wa); // [RULE23]
		rd_ev = cs_ok && (c.amode ? (rv && !ra) : ra);
		pe_ev = cs_ok && pa && !pva;
		len = '0;
		for (int i = 0; i < sfi_pkg::NF; i++) begin
			sz[i] = c.ep[i].size_1024 ? sfi_pkg::PKT_1024 : sfi_pkg::PKT_512;
			nb[i] = (c.ep[i].bufs == sfi_pkg::BUF_4X) ? 3'h4 :
				((c.ep[i].bufs == sfi_pkg::BUF_3X) ? 3'h3 : 3'h2); // [RULE16]
			cap[i] = 13'(sz[i]) * 13'(nb[i]);
			// Flags derived from the registered counts [RULE27]
			full[i] = c.ep[i].dir_in ? (s.cnt[i] >= nb[i]) :
				(s.bytes[i] > cap[i] - 13'h2);
			empty[i] = (s.bytes[i] == '0) && (s.cnt[i] == 3'h0);
			if (!c.ep[i].dir_in) begin
				lvl[i] = c.ep[i].level_compare_direction ?
					(s.bytes[i] >= c.ep[i].level_threshold_count) :
					(s.bytes[i] <= c.ep[i].level_threshold_count); // [RULE19]
			end else if (c.ep[i].packet_status_mode) begin
				lvl[i] = c.ep[i].level_compare_direction ?
					(s.cur[i][9:0] >= c.ep[i].level_threshold_count[9:0]) :
					(s.cur[i][9:0] <= c.ep[i].level_threshold_count[9:0]);
				// [RULE20]
			end else begin
				lvl[i] = c.ep[i].level_compare_direction ?
					({s.cnt[i], s.cur[i][9:0]} >=
					{c.ep[i].committed_packet_threshold,
					c.ep[i].level_threshold_count[9:0]}) :
					({s.cnt[i], s.cur[i][9:0]} <=
					{c.ep[i].committed_packet_threshold,
					c.ep[i].level_threshold_count[9:0]}); // [RULE21]
			end
			// USB side takes the oldest committed IN packet
			if (s.rel2[i] != s.rel_seen[i]) begin
				next_s.rel_seen[i] = s.rel2[i];
				if (c.ep[i].dir_in && s.cnt[i] != 3'h0) begin
					len = s.lens[i][s.head[i]];
					next_s.bytes[i] = s.bytes[i] - BW'(len);
					next_s.rp[i] = s.rp[i] + PW'(len[10:1]) + PW'(len[0]);
					next_s.head[i] = s.head[i] + 2'h1;
					next_s.cnt[i] = s.cnt[i] - 3'h1;
				end
			end
		end
		// Master write wins over a window write in the same cycle
		wr_ok = wr_ev && c.ep[f].dir_in && !full[f] &&
			(s.cur[f] < sz[f]); // [RULE9]
		push = wr_ok;
		pf = f;
		pd = p.data;
		if (!wr_ok && (s.req2 != s.req_seen)) begin
			next_s.req_seen = s.req2;
			next_s.ack = !s.ack;
			if (wc.wr) begin
				push = !full[wc.fifo]; // [RULE13]
				pf = wc.fifo;
				pd = wc.data;
			end else begin
				next_s.rdata = lmem[wc.fifo][s.rp[wc.fifo] + wc.off];
			end
		end
		if (push) begin
			lmem_we = 1'b1;
			lmem_f = pf;
			lmem_a = s.wp[pf];
			lmem_d = pd;
			next_s.wp[pf] = s.wp[pf] + 11'h1;
			next_s.bytes[pf] = next_s.bytes[pf] + 13'h2; // [RULE27]
			if (c.ep[pf].dir_in) begin
				next_s.cur[pf] = s.cur[pf] + 11'h2;
			end
		end
		// Packet commit: packet-end or auto-in length reached
		nc = next_s.cur[f];
		pe_ok = pe_ev && c.ep[f].dir_in && next_s.cnt[f] < nb[f] &&
			(nc != 11'h0 || c.ep[f].zero_len); // [RULE1] [RULE4] [RULE6]
		au_ok = wr_ok && c.ep[f].auto_in_commit &&
			nc >= c.ep[f].auto_in_packet_length; // [RULE2]
		if (pe_ok || au_ok) begin
			next_s.lens[f][2'(next_s.head[f] + next_s.cnt[f][1:0])] = nc;
			next_s.cnt[f] = next_s.cnt[f] + 3'h1;
			next_s.cur[f] = 11'h0;
		end
		rd_ok = rd_ev && !c.ep[f].dir_in && !empty[f]; // [RULE10] [RULE12]
		if (rd_ok) begin
			next_s.rp[f] = s.rp[f] + 11'h1;
			next_s.bytes[f] = next_s.bytes[f] - 13'h2;
		end
		// Indexed flags and bus drive of the selected FIFO
		next_s.fa = lvl[f]; // [RULE22] [RULE25]
		next_s.fb = full[f] ~^ c.pin_polarity_config[sfi_pkg::POL_FULL];
		next_s.fc = empty[f] ~^ c.pin_polarity_config[sfi_pkg::POL_EMPTY];
		next_s.oe_n = !(cs_ok && !c.ep[f].dir_in &&
			(p.oe == c.pin_polarity_config[sfi_pkg::POL_OE])); // [RULE8]
		next_s.dout = lmem[f][next_s.rp[f]];
	end

	// Link register
	always_ff @(posedge interface_clock or posedge reset) begin
		if (reset) begin
			s <= LINK_RESET; // [RULE18]
		end else begin
			s <= next_s;
		end
	end

	// FIFO storage, word per entry
	always_ff @(posedge interface_clock) begin
		if (lmem_we) begin
			lmem[lmem_f][lmem_a] <= lmem_d;
		end
	end

	assign win_done = q.done;
	assign win_rdata = q.rdata;
	assign fifo_data_bus_out = s.dout;
	assign fifo_data_bus_oe_n = s.oe_n;
	assign flag_pin_a = s.fa;
	assign flag_pin_b = s.fb;
	assign flag_pin_c = s.fc;

	a_cs_float: // [RULE8]
	assert property (@(posedge interface_clock) disable iff (reset)
		!cs_ok && s.req2 == s.req_seen |=> s.oe_n && $stable(s.wp))
		else $error("bus driven or write taken while deselected");

	a_sync_write: // [RULE23]
	assert property (@(posedge interface_clock) disable iff (reset)
		!c.amode && wr_ok |=> s.wp[$past(f)] == $past(s.wp[f]) + 11'h1)
		else $error("sync write did not advance the pointer");

	a_pend_commit: // [RULE1]
	assert property (@(posedge interface_clock) disable iff (reset)
		pe_ok |=> s.cur[$past(f)] == 11'h0)
		else $error("packet end did not commit the packet");

	a_auto_commit: // [RULE2]
	assert property (@(posedge interface_clock) disable iff (reset)
		wr_ok && !au_ok && !pe_ok |=>
		s.cur[$past(f)] == $past(s.cur[f]) + 11'h2)
		else $error("write byte count wrong or early commit");

	a_zero_block: // [RULE4]
	assert property (@(posedge interface_clock) disable iff (reset)
		pe_ev && !wr_ok && s.req2 == s.req_seen && s.cur[f] == 11'h0 &&
		!c.ep[f].zero_len |=>
		s.cnt[$past(f)] <= $past(s.cnt[f]))
		else $error("zero length packet committed while disabled");

	a_async_read: // [RULE26]
	assert property (@(posedge interface_clock) disable iff (reset)
		c.amode && rd_ok |=> s.rp[$past(f)] == $past(s.rp[f]) + 11'h1)
		else $error("async read release did not advance pointer");

	a_full_pin: // [RULE25]
	assert property (@(posedge interface_clock) disable iff (reset)
		full[f] && !c.pin_polarity_config[sfi_pkg::POL_FULL] |=> !s.fb)
		else $error("full flag pin not asserted");

	a_level_out: // [RULE19]
	assert property (@(posedge interface_clock) disable iff (reset)
		!c.ep[f].dir_in && c.ep[f].level_compare_direction &&
		s.bytes[f] >= c.ep[f].level_threshold_count |=> s.fa)
		else $error("level flag missed its threshold");

	a_fixed_size: // [RULE15]
	assert property (@(posedge interface_clock) disable iff (reset)
		cap[1] == 13'h0400 && cap[3] == 13'h0400)
		else $error("fixed endpoint capacity altered");
endmodule

// File: bench/sfi_master_model.sv
// Behavioural external master driving the slave FIFO port pins
`timescale 1ns/10ps
module sfi_master_model (
	input  wire logic        interface_clock,
	input  wire logic [5:0]  pol,
	input  wire logic [15:0] bus_out,
	input  wire logic        bus_oe_n,
	input  wire logic        full_n,
	input  wire logic        empty_n,
	output logic [1:0]       sel,
	output logic             cs_n,
	output logic             wr,
	output logic             rd,
	output logic             oe,
	output logic             pend,
	output logic [15:0]      data
);
	localparam int W = sfi_pkg::POL_WR;
	localparam int R = sfi_pkg::POL_RD;
	localparam int O = sfi_pkg::POL_OE;
	localparam int P = sfi_pkg::POL_PEND;

	// Strobes start inactive for the reset polarity, chip select asserted
	initial begin
		sel = 2'h0;
		cs_n = 1'b0;
		{wr, rd, oe, pend} = 4'hF;
		data = 16'h0000;
	end

	// Return every strobe to its inactive level
	task automatic idle();
		@(posedge interface_clock);
		wr <= ~pol[W];
		rd <= ~pol[R];
		oe <= ~pol[O];
		pend <= ~pol[P];
	endtask

	// Point at a FIFO and let its flags settle
	task automatic pick(input logic [1:0] s);
		@(posedge interface_clock);
		sel <= s;
		repeat (3) @(posedge interface_clock);
		@(negedge interface_clock);
	endtask

	// Bounded wait for not full (room=1) or not empty (room=0); flag
	// polarity follows the config, looked at half a clock after launch
	task automatic wait_flag(input bit room);
		for (int i = 0; i < 50 && (room ?
			full_n ^ pol[sfi_pkg::POL_FULL] :
			empty_n ^ pol[sfi_pkg::POL_EMPTY]) !== 1'b1; i++)
			@(negedge interface_clock);
	endtask

	// Back-to-back one-clock writes, bus released to inverse after
	task automatic sync_write(input logic [1:0] s, input logic [15:0] d,
		input int n);
		pick(s);
		wait_flag(1'b1);
		for (int i = 0; i < n; i++) begin
			@(posedge interface_clock);
			data <= d + 16'(i);
			wr <= pol[W];
		end
		@(posedge interface_clock);
		wr <= ~pol[W];
		data <= ~data;
	endtask

	// Commit a short or empty packet only while a buffer is free
	task automatic pulse_end();
		wait_flag(1'b1);
		@(posedge interface_clock);
		pend <= pol[P];
		@(posedge interface_clock);
		pend <= ~pol[P];
	endtask

	// Output enable, wait not empty, sample, one-clock read strobe
	task automatic sync_read(input logic [1:0] s, output logic [15:0] q,
		output logic lo);
		pick(s);
		@(posedge interface_clock);
		oe <= pol[O];
		wait_flag(1'b0);
		repeat (2) @(posedge interface_clock);
		@(negedge interface_clock);
		q = bus_out;
		lo = bus_oe_n;
		@(posedge interface_clock);
		rd <= pol[R];
		@(posedge interface_clock);
		rd <= ~pol[R];
		oe <= ~pol[O];
	endtask

	// Strobe held active then inactive long enough to pass the sync
	task automatic async_write(input logic [1:0] s, input logic [15:0] d);
		pick(s);
		wait_flag(1'b1);
		@(posedge interface_clock);
		data <= d;
		wr <= pol[W];
		repeat (4) @(posedge interface_clock);
		wr <= ~pol[W];
		repeat (4) @(posedge interface_clock);
		data <= ~d;
	endtask

	// Strobes active, sample, release read, then output enable
	task automatic async_read(input logic [1:0] s, output logic [15:0] q);
		pick(s);
		wait_flag(1'b0);
		@(posedge interface_clock);
		oe <= pol[O];
		rd <= pol[R];
		repeat (4) @(posedge interface_clock);
		@(negedge interface_clock);
		q = bus_out;
		@(posedge interface_clock);
		rd <= ~pol[R];
		repeat (4) @(posedge interface_clock);
		oe <= ~pol[O];
	endtask
endmodule

// File: bench/sfi_slave_fifo_test.sv
// Self-checking bench for the slave FIFO block
`timescale 1ns/10ps
module sfi_slave_fifo_test;
	logic                      clk;
	logic                      reset;
	logic                      iclk;
	logic                      cfg_load;
	sfi_pkg::sfi_ep_type [3:0] cfg_ep;
	sfi_pkg::sfi_ep_type       e8;
	logic [5:0]                pol;
	logic [7:0]                port_a;
	logic                      async_mode;
	logic                      win_req;
	sfi_pkg::sfi_win_type      win_cmd;
	logic                      win_done;
	logic [15:0]               win_rdata;
	logic [3:0]                usb_release;
	logic [1:0]                sel;
	logic                      cs_n, wr, rd, oe, pend;
	logic [15:0]               bus_in;
	logic [15:0]               bus_out;
	logic                      oe_n, fa, fb, fc, lo;
	logic [15:0]               q;
	int                        n_fail = 0;
	int                        checks = 0;

	sfi_slave_fifo dut (.clk(clk), .reset(reset), .interface_clock(iclk),
		.cfg_load(cfg_load), .cfg_ep(cfg_ep), .pin_polarity_config(pol),
		.port_a_alt_config(port_a), .async_mode(async_mode),
		.win_req(win_req), .win_cmd(win_cmd), .win_done(win_done),
		.win_rdata(win_rdata), .usb_release(usb_release),
		.fifo_select(sel), .fifo_chip_select(cs_n),
		.fifo_write_strobe(wr), .fifo_read_strobe(rd),
		.fifo_output_enable(oe), .packet_end_strobe(pend),
		.fifo_data_bus_in(bus_in), .fifo_data_bus_out(bus_out),
		.fifo_data_bus_oe_n(oe_n), .flag_pin_a(fa), .flag_pin_b(fb),
		.flag_pin_c(fc));

	sfi_master_model m (.interface_clock(iclk), .pol(pol),
		.bus_out(bus_out), .bus_oe_n(oe_n), .full_n(fb), .empty_n(fc),
		.sel(sel), .cs_n(cs_n), .wr(wr), .rd(rd), .oe(oe), .pend(pend),
		.data(bus_in));

	// Core clock 40 ns
	always #20 clk = ~clk;

	// Port clock 30 ns, offset from the core clock
	initial begin
		iclk = 1'b0;
		#7;
		forever #15 iclk = ~iclk;
	end

	task automatic chk_flag(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chk_word(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One processor window access, bounded wait for done
	task automatic win(input logic [1:0] f, input logic w,
		input logic [10:0] o, input logic [15:0] d);
		@(posedge clk);
		win_cmd <= '{f, w, o, d};
		win_req <= 1'b1;
		@(posedge clk);
		win_req <= 1'b0;
		for (int i = 0; i < 40 && win_done !== 1'b1; i++) @(negedge clk);
		chk_flag("win_done", 1'b1, win_done);
	endtask

	// Load endpoint eight setup, polarity, chip select and mode
	task automatic load(input logic [5:0] p, input logic [7:0] a,
		input logic am);
		m.pick(2'h0);
		@(posedge clk);
		cfg_ep[3] <= e8;
		pol <= p;
		port_a <= a;
		async_mode <= am;
		cfg_load <= 1'b1; // Firmware side set up
		@(posedge clk);
		cfg_load <= 1'b0;
		repeat (8) @(posedge iclk);
		m.idle();
	endtask

	// USB takes the oldest committed packet of one FIFO
	task automatic rel(input int k);
		@(posedge clk);
		usb_release[k] <= 1'b1;
		@(posedge clk);
		usb_release <= 4'h0;
		repeat (8) @(posedge clk);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#1000000;
		n_fail++;
		$display("Error watchdog expected end seen hang");
		wrap_up();
	end

	// Test sequence
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		cfg_load = 1'b0;
		cfg_ep = sfi_pkg::CFG_RESET.ep;
		e8 = sfi_pkg::EP_IN_RESET;
		pol = sfi_pkg::POL_RESET;
		port_a = 8'h00;
		async_mode = 1'b0;
		win_req = 1'b0;
		win_cmd = '0;
		usb_release = 4'h0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		repeat (6) @(posedge iclk);
		m.pick(2'h0);
		chk_flag("a ep2", 1'b0, fa);
		chk_flag("b ep2", 1'b1, fb);
		chk_flag("c ep2", 1'b0, fc);
		m.pick(2'h2);
		chk_flag("a ep6", 1'b1, fa);
		$display("test reset done");
		for (int i = 0; i < 256; i++)
			win(2'h0, 1'b1, 11'h000, 16'h1000 + 16'(i));
		m.pick(2'h0);
		chk_flag("a ep2 half", 1'b1, fa);
		chk_flag("c ep2 data", 1'b1, fc);
		win(2'h0, 1'b0, 11'h001, 16'h0000);
		chk_word("win ep2", 16'h1001, win_rdata);
		m.sync_read(2'h0, q, lo);
		chk_word("rd ep2", 16'h1000, q);
		chk_flag("oe_n rd", 1'b0, lo);
		m.pick(2'h0);
		chk_flag("a ep2 510", 1'b0, fa);
		m.pick(2'h1);
		chk_flag("c ep4", 1'b0, fc);
		$display("test out fifo done");
		m.sync_write(2'h2, 16'hA000, 3);
		for (int i = 0; i < 3; i++) begin
			win(2'h2, 1'b0, 11'(i), 16'h0000);
			chk_word("win ep6", 16'hA000 + 16'(i), win_rdata);
		end
		m.pick(2'h2);
		chk_flag("a ep6 open", 1'b1, fa);
		m.pulse_end();
		m.sync_write(2'h2, 16'hA003, 1);
		m.pick(2'h2);
		chk_flag("a ep6 commit", 1'b0, fa);
		$display("test packet end done");
		e8.auto_in_commit = 1'b1;
		e8.zero_len = 1'b1;
		e8.auto_in_packet_length = 11'h004;
		load(6'h20, 8'h00, 1'b0);
		m.sync_write(2'h3, 16'hC000, 4);
		m.pick(2'h3);
		chk_flag("b ep8 full", 1'b0, fb);
		rel(3);
		rel(3);
		m.pick(2'h3);
		chk_flag("b ep8 free", 1'b1, fb);
		m.pulse_end();
		m.sync_write(2'h3, 16'hC004, 1);
		m.pick(2'h3);
		chk_flag("a ep8 zero", 1'b0, fa);
		$display("test auto in done");
		load(6'h20, 8'h40, 1'b0);
		@(posedge iclk) m.cs_n <= 1'b1;
		m.sync_write(2'h3, 16'hC005, 1);
		m.sync_read(2'h0, q, lo);
		m.pick(2'h3);
		chk_flag("b ep8 desel", 1'b1, fb);
		chk_flag("oe_n desel", 1'b1, lo);
		@(posedge iclk) m.cs_n <= 1'b0;
		$display("test chip select done");
		// Status-mode level, inverted flags, fixed buffering of eight
		e8.xfer = sfi_pkg::sfi_iso;
		e8.size_1024 = 1'b1;
		e8.bufs = sfi_pkg::BUF_4X;
		e8.packet_status_mode = 1'b1;
		e8.level_compare_direction = 1'b1;
		e8.committed_packet_threshold = 3'h2;
		e8.level_threshold_count = 13'h0004;
		e8.auto_in_packet_length = 11'h008;
		load(6'h23, 8'h00, 1'b0);
		m.sync_write(2'h3, 16'hC006, 1);
		m.pick(2'h3);
		chk_flag("a ep8 status", 1'b1, fa);
		chk_flag("b ep8 high", 1'b0, fb);
		chk_flag("c ep8 high", 1'b0, fc);
		m.pulse_end();
		m.pick(2'h3);
		chk_flag("b ep8 2x", 1'b1, fb);
		chk_flag("a ep8 reset", 1'b0, fa);
		$display("test config done");
		load(6'h20, 8'h00, 1'b1);
		m.async_write(2'h2, 16'hBEEF);
		win(2'h2, 1'b0, 11'h004, 16'h0000);
		chk_word("async wr", 16'hBEEF, win_rdata);
		m.async_read(2'h0, q);
		chk_word("async rd", 16'h1001, q);
		win(2'h0, 1'b0, 11'h000, 16'h0000);
		chk_word("async ptr", 16'h1002, win_rdata);
		$display("test async done");
		wrap_up();
	end
endmodule
